// ---- hdl/pmrb_defs.svh ----
// Purpose: Offsets, field positions and reset values of the rail-one register bank.
// Assumes: Eight-bit registers reached by a byte-wide register port.
// Notes:   Definitions only.
`ifndef PMRB_DEFS_SVH
`define PMRB_DEFS_SVH

// ============================================================
// Register offsets
`define PMRB_ADDR_CONTROL_B     8'h01
`define PMRB_ADDR_ALERT_ENABLE  8'h02
`define PMRB_ADDR_FAULT_FLAGS   8'h03
`define PMRB_ADDR_RESOLUTION    8'h04

// ============================================================
// Control, resolution and fault fields
`define PMRB_CTL_ALERT_CLR      7
`define PMRB_CTL_CLR_ON_READ    5
`define PMRB_CTL_AUTO_WAKE      4
`define PMRB_CTL_PEAK_RST       3
`define PMRB_CTL_GLOBAL_RST     0
`define PMRB_CTL_WMASK          8'hB9
`define PMRB_RES_BIT            7
`define PMRB_RES_WMASK          8'h80
// Over-max crossings sit in odd bits, under-min crossings in even bits.
`define PMRB_OVER_MASK          8'hAA
`define PMRB_UNDER_MASK         8'h55

// ============================================================
// Reset values
`define PMRB_RST_BYTE           8'h00
`define PMRB_RST_BIT            1'b0
`define PMRB_RST_ALERT_N        1'b1

`endif

// ---- hdl/pmrb_pkg.sv ----
// Purpose: Types shared by the rail-one register bank.
// Assumes: Nothing beyond the defines header.
// Notes:   Holds types only.
package pmrb_pkg;
	typedef logic [7:0] pmrb_byte_t;
	// Alert-enable and fault bit pairs, maximum in odd bit.
	typedef struct packed {
		logic power_max;
		logic power_min;
		logic shunt_max;
		logic shunt_min;
		logic volt_max;
		logic volt_min;
		logic aux_max;
		logic aux_min;
	} pmrb_pair_s;
endpackage

// ---- hdl/pmrb_regs.sv ----
// Purpose: Control, alert-enable, fault and resolution registers, rail one.
// Assumes: Host serial-bus logic outside decodes accesses into strobes.
// Notes:   One clock, synchronous active-high reset.
// Notes on behaviour
// - With alert-clear enabled, being addressed releases the alert output, except in a cycle that brings a crossing.
// - Reserved control and resolution bits read zero and ignore writes.
// - With clear-on-read set, reading the fault register clears it.
// - With auto-wake set, a stuck-bus timeout ends shutdown.
// - Writing one to peak-hold reset clears all min and max registers.
// - Writing one to global reset returns all registers to reset values, except that the peak reset output pulses high.
// - Alert-enable bits pair power, shunt difference, rail voltage, aux.
// - A max alert fires above max threshold, a min alert below min.
// - All alert-enable bits reset to zero.
// - Fault bits pair over (odd) and under (even) in the same order.
// - A fault flag reads one once its crossing occurred, zero at reset.
// - The resolution bit selects 8-bit when set, 12-bit when clear.
`timescale 1ns/1ps
`include "pmrb_defs.svh"
`default_nettype none

module pmrb_regs (
	input  wire logic                clk_sys_i,
	input  wire logic                rst_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	input  wire pmrb_pkg::pmrb_byte_t reg_addr_i,
	input  wire pmrb_pkg::pmrb_byte_t reg_wdata_i,
	input  wire logic                bus_addressed_i,
	input  wire logic                stuck_bus_timeout_i,
	input  wire logic                shutdown_req_i,
	input  wire pmrb_pkg::pmrb_byte_t over_max_i,
	input  wire pmrb_pkg::pmrb_byte_t under_min_i,
	output logic                     alert_n_o,
	output pmrb_pkg::pmrb_byte_t     reg_rdata_o,
	output logic                     shutdown_o,
	output logic                     peak_reset_o,
	output logic                     low_resolution_o
);
	import pmrb_pkg::*;

	// ============================================================
	// State
	pmrb_byte_t ctl_reg;
	pmrb_byte_t ctl_next;
	pmrb_byte_t alert_en_reg;
	pmrb_byte_t alert_en_next;
	pmrb_byte_t fault_reg;
	pmrb_byte_t fault_next;
	pmrb_byte_t res_reg;
	pmrb_byte_t res_next;
	pmrb_byte_t rdata_reg;
	pmrb_byte_t rdata_next;
	logic       alert_reg;
	logic       alert_next;
	logic       alert_n_reg;
	logic       shdn_reg;
	logic       shdn_next;
	logic       peak_reg;
	logic       peak_next;
	logic       wr_ctl;
	logic       wr_alert;
	logic       wr_fault;
	logic       wr_res;
	logic       rd_fault;
	logic       soft_rst;
	logic       any_fault;
	pmrb_byte_t events;

	function automatic logic hit(input pmrb_byte_t a, input pmrb_byte_t o);
		hit = (a == o);
	endfunction

	// ============================================================
	// Next-state logic
	always_comb begin
		wr_ctl   = reg_wr_i && hit(reg_addr_i, `PMRB_ADDR_CONTROL_B);
		wr_alert = reg_wr_i && hit(reg_addr_i, `PMRB_ADDR_ALERT_ENABLE);
		wr_fault = reg_wr_i && hit(reg_addr_i, `PMRB_ADDR_FAULT_FLAGS);
		wr_res   = reg_wr_i && hit(reg_addr_i, `PMRB_ADDR_RESOLUTION);
		rd_fault = reg_rd_i && hit(reg_addr_i, `PMRB_ADDR_FAULT_FLAGS);
		// Writing one to the self-clearing reset bit is the reset itself.
		soft_rst = wr_ctl && reg_wdata_i[`PMRB_CTL_GLOBAL_RST];
		// Crossings are strict comparisons done upstream, max odd, min even.
		events = (over_max_i & `PMRB_OVER_MASK) | (under_min_i & `PMRB_UNDER_MASK);
		ctl_next = ctl_reg;
		if (wr_ctl) begin
			ctl_next = reg_wdata_i & `PMRB_CTL_WMASK;
		end
		// Reset bits self-clear so a stale one never re-fires.
		ctl_next[`PMRB_CTL_PEAK_RST]   = `PMRB_RST_BIT;
		ctl_next[`PMRB_CTL_GLOBAL_RST] = `PMRB_RST_BIT;
		peak_next = wr_ctl && reg_wdata_i[`PMRB_CTL_PEAK_RST];
		alert_en_next = wr_alert ? reg_wdata_i : alert_en_reg;
		res_next = res_reg;
		if (wr_res) begin
			res_next = reg_wdata_i & `PMRB_RES_WMASK;
		end
		fault_next = fault_reg;
		if (wr_fault) begin
			fault_next = fault_reg & reg_wdata_i;
		end
		if (rd_fault && ctl_reg[`PMRB_CTL_CLR_ON_READ]) begin
			fault_next = `PMRB_RST_BYTE;
		end
		// A new crossing wins over a clear in the same cycle.
		fault_next = fault_next | events;
		any_fault = |(fault_next & alert_en_next);
		alert_next = alert_reg;
		if (any_fault && !(fault_next == fault_reg && alert_en_next == alert_en_reg)) begin
			alert_next = 1'b1;
		end else if (!any_fault) begin
			alert_next = 1'b0;
		end
		// Addressing releases the alert until a new fault arrives.
		if (bus_addressed_i && ctl_reg[`PMRB_CTL_ALERT_CLR] && events == `PMRB_RST_BYTE) begin
			alert_next = 1'b0;
		end
		shdn_next = shdn_reg;
		if (shutdown_req_i) begin
			shdn_next = 1'b1;
		end
		if (stuck_bus_timeout_i && ctl_reg[`PMRB_CTL_AUTO_WAKE]) begin
			shdn_next = 1'b0;
		end
		unique case (reg_addr_i)
			`PMRB_ADDR_CONTROL_B:    rdata_next = ctl_reg;
			`PMRB_ADDR_ALERT_ENABLE: rdata_next = alert_en_reg;
			`PMRB_ADDR_FAULT_FLAGS:  rdata_next = fault_reg;
			`PMRB_ADDR_RESOLUTION:   rdata_next = res_reg;
			default:                 rdata_next = `PMRB_RST_BYTE;
		endcase
		if (!reg_rd_i) begin
			rdata_next = rdata_reg;
		end
	end

	// ============================================================
	// Registers
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || soft_rst) begin
			ctl_reg      <= `PMRB_RST_BYTE;
			alert_en_reg <= `PMRB_RST_BYTE;
			fault_reg    <= `PMRB_RST_BYTE;
			res_reg      <= `PMRB_RST_BYTE;
			rdata_reg    <= `PMRB_RST_BYTE;
			alert_reg    <= `PMRB_RST_BIT;
			alert_n_reg  <= `PMRB_RST_ALERT_N;
			shdn_reg     <= `PMRB_RST_BIT;
			peak_reg     <= soft_rst && !rst_i;
		end else begin
			ctl_reg      <= ctl_next;
			alert_en_reg <= alert_en_next;
			fault_reg    <= fault_next;
			res_reg      <= res_next;
			rdata_reg    <= rdata_next;
			alert_reg    <= alert_next;
			// The pin has its own flop so no gate sits between it and a register.
			alert_n_reg  <= !alert_next;
			shdn_reg     <= shdn_next;
			peak_reg     <= peak_next;
		end
	end

	always_comb begin
		alert_n_o        = alert_n_reg;
		reg_rdata_o      = rdata_reg;
		shutdown_o       = shdn_reg;
		peak_reset_o     = peak_reg;
		low_resolution_o = res_reg[`PMRB_RES_BIT];
	end
endmodule

`default_nettype wire

// ---- test/pmrb_regs_sva.sv ----
// Purpose: Port-level checks of the rail-one register bank.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Register contents are compared by the bench.
`timescale 1ns/1ps
`default_nettype none
module pmrb_regs_chk (
	input wire logic                 clk_sys_i,
	input wire logic                 rst_i,
	input wire logic                 reg_wr_i,
	input wire logic                 reg_rd_i,
	input wire pmrb_pkg::pmrb_byte_t reg_addr_i,
	input wire pmrb_pkg::pmrb_byte_t reg_wdata_i,
	input wire logic                 stuck_bus_timeout_i,
	input wire logic                 shutdown_req_i,
	input wire pmrb_pkg::pmrb_byte_t reg_rdata_o,
	input wire logic                 shutdown_o,
	input wire logic                 peak_reset_o
);
	import pmrb_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire logic ctl_wr = reg_wr_i && reg_addr_i == 8'h01;
	wire logic rd_res = reg_rd_i && reg_addr_i == 8'h04;
	property p_peak; ctl_wr && (reg_wdata_i[3] || reg_wdata_i[0])
		|=> peak_reset_o; endproperty
	a_peak: assert property (p_peak) else $error("no peak reset");
	property p_pulse; peak_reset_o && !ctl_wr |=> !peak_reset_o; endproperty
	a_pulse: assert property (p_pulse) else $error("long pulse");
	property p_ctl; reg_rd_i && reg_addr_i == 8'h01
		|=> (reg_rdata_o & 8'h4F) == 8'h00; endproperty
	a_ctl: assert property (p_ctl) else $error("ctl reserved");
	property p_res; rd_res |=> reg_rdata_o[6:0] == 7'h00; endproperty
	a_res: assert property (p_res) else $error("res reserved");
	property p_unm; reg_rd_i && (reg_addr_i == 8'h00 || reg_addr_i > 8'h04)
		|=> reg_rdata_o == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped data");
	property p_sd; shutdown_req_i && !stuck_bus_timeout_i |=> shutdown_o;
	endproperty
	a_sd: assert property (p_sd) else $error("no shutdown");
	property p_sdh; !shutdown_o && !shutdown_req_i |=> !shutdown_o;
	endproperty
	a_sdh: assert property (p_sdh) else $error("stray shutdown");
	property p_hold; !reg_rd_i && !reg_wr_i |=> $stable(reg_rdata_o);
	endproperty
	a_hold: assert property (p_hold) else $error("rdata moved");
	c_peak: cover property (peak_reset_o);
	c_wake: cover property ($fell(shutdown_o));
	c_res: cover property (rd_res);
endmodule
bind pmrb_regs pmrb_regs_chk i_pmrb_regs_chk (.*);
`default_nettype wire

// ---- test/pmrb_host.sv ----
// Purpose: Host master that issues single-byte register accesses.
// Assumes: Strobes launched 1 ns after a rising edge, one cycle long.
// Notes:   Released address and data lines are inverted, never held.
`timescale 1ns/1ps
`default_nettype none
module pmrb_host (
	input  wire logic                clk_sys_i,
	output var logic                 reg_wr_o,
	output var logic                 reg_rd_o,
	output var pmrb_pkg::pmrb_byte_t reg_addr_o,
	output var pmrb_pkg::pmrb_byte_t reg_wdata_o
);
	import pmrb_pkg::*;
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end
	// Reset bits are written only to reset; they self-clear after.
	task automatic acc(input logic w, input pmrb_byte_t a, input pmrb_byte_t d);
		@(posedge clk_sys_i);
		#1;
		reg_wr_o = w;
		reg_rd_o = !w;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(posedge clk_sys_i);
		#1;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask
endmodule
`default_nettype wire

// ---- test/tb_monitor_ctrl_alert_fault_regs.sv ----
// Purpose: Register-level test of the rail-one bank.
// Assumes: Host model issues accesses; bench drives event pulses.
// Notes:   Fault latency is covered by an access between event and check.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	err_count++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_monitor_ctrl_alert_fault_regs;
	import pmrb_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wr, rd, adr, tmo, sdq, aln, sd, pk, lr;
	pmrb_byte_t addr, wd, om = 8'h00, um = 8'h00, rdata;
	int err_count = 0, samples_checked = 0, cyc = 0;
	pmrb_regs i_pmrb_regs (.clk_sys_i(clk), .rst_i(rst), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd),
		.bus_addressed_i(adr), .stuck_bus_timeout_i(tmo),
		.shutdown_req_i(sdq), .over_max_i(om), .under_min_i(um),
		.alert_n_o(aln), .reg_rdata_o(rdata), .shutdown_o(sd),
		.peak_reset_o(pk), .low_resolution_o(lr));
	pmrb_host i_pmrb_host (.clk_sys_i(clk), .reg_wr_o(wr), .reg_rd_o(rd),
		.reg_addr_o(addr), .reg_wdata_o(wd));
	always #50 clk = ~clk;
	task automatic end_sim;
		$display("Checks %0d, errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			end_sim();
		end
	end
	task automatic w(input pmrb_byte_t a, input pmrb_byte_t d);
		i_pmrb_host.acc(1'b1, a, d);
	endtask
	task automatic r(input pmrb_byte_t a, input pmrb_byte_t e);
		i_pmrb_host.acc(1'b0, a, 8'h00);
		`CHK("rdata", e, rdata)
	endtask
	// One-cycle event pulse: over, under, addressed, timeout, shutdown.
	task automatic ev(input pmrb_byte_t o, u, input logic b, t, s);
		@(posedge clk);
		#1;
		{om, um, adr, tmo, sdq} = {o, u, b, t, s};
		@(posedge clk);
		#1;
		{om, um, adr, tmo, sdq} = 19'h0;
	endtask
	initial begin
		{adr, tmo, sdq} = 3'b000;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int a = 0; a < 6; a++) r(a[7:0], 8'h00);
		`CHK("alert", 1'b1, aln)
		w(8'h02, 8'hFF);
		r(8'h02, 8'hFF);
		w(8'h04, 8'hFF);
		r(8'h04, 8'h80);
		`CHK("lowres", 1'b1, lr)
		ev(8'h00, 8'h01, 1'b0, 1'b0, 1'b0);
		r(8'h03, 8'h01);
		r(8'h03, 8'h01);
		`CHK("alert", 1'b0, aln)
		ev(8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
		`CHK("alert", 1'b0, aln)
		w(8'h03, 8'h00);
		r(8'h03, 8'h00);
		`CHK("alert", 1'b1, aln)
		ev(8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
		ev(8'h00, 8'h00, 1'b0, 1'b1, 1'b0);
		`CHK("sd", 1'b1, sd)
		w(8'h01, 8'hFE);
		`CHK("peak", 1'b1, pk)
		r(8'h01, 8'hB0);
		`CHK("peak", 1'b0, pk)
		ev(8'h00, 8'h00, 1'b0, 1'b1, 1'b0);
		`CHK("sd", 1'b0, sd)
		ev(8'h80, 8'h00, 1'b0, 1'b0, 1'b0);
		r(8'h02, 8'hFF);
		`CHK("alert", 1'b0, aln)
		ev(8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
		`CHK("alert", 1'b1, aln)
		r(8'h03, 8'h80);
		r(8'h03, 8'h00);
		w(8'h01, 8'h01);
		r(8'h02, 8'h00);
		r(8'h04, 8'h00);
		`CHK("lowres", 1'b0, lr)
		end_sim();
	end
endmodule
`default_nettype wire
